// file: core/bfiu_params.svh
// register map, field positions and reset values of the bit and flag unit
`ifndef BFIU_PARAMS_SVH
`define BFIU_PARAMS_SVH

`define BFIU_ADDR_W        8
`define BFIU_OFS_FLAGS     8'h00
`define BFIU_OFS_OPERAND   8'h04
`define BFIU_OFS_CMD       8'h08
`define BFIU_OFS_STATUS    8'h0C
`define BFIU_OFS_CTRL      8'h10

`define BFIU_FLAG_C        0
`define BFIU_FLAG_Z        1
`define BFIU_FLAG_N        2
`define BFIU_FLAG_V        3
`define BFIU_FLAG_S        4
`define BFIU_FLAG_H        5
`define BFIU_FLAG_T        6
`define BFIU_FLAG_I        7

`define BFIU_CMD_OP_LSB    0
`define BFIU_CMD_OP_MSB    4
`define BFIU_CMD_SEL_LSB   8
`define BFIU_CMD_SEL_MSB   10
`define BFIU_CTRL_RESUME   0
`define BFIU_STAT_HALTED   0
`define BFIU_STAT_DBGEN    1
`define BFIU_STAT_PEND     2

`define BFIU_FLAGS_RST     8'h00
`define BFIU_OPERAND_RST   8'h00
`define BFIU_CMD_RST       11'h000
`define BFIU_OP_CYCLES     1

`endif

// file: core/bfiu_pkg.sv
// types shared by the bit and flag unit
package bfiu_pkg;

  typedef enum logic [4:0] {
    BFIU_OP_NOP   = 5'h00,
    BFIU_OP_ROL   = 5'h01,
    BFIU_OP_ROR   = 5'h02,
    BFIU_OP_LSR   = 5'h03,
    BFIU_OP_ASR   = 5'h04,
    BFIU_OP_SWAP  = 5'h05,
    BFIU_OP_BST   = 5'h06,
    BFIU_OP_BLD   = 5'h07,
    BFIU_OP_FSET  = 5'h08,
    BFIU_OP_FCLR  = 5'h09,
    BFIU_OP_SLEEP = 5'h0A,
    BFIU_OP_WDR   = 5'h0B,
    BFIU_OP_BREAK = 5'h0C
  } bfiu_op_t;

  typedef enum logic [2:0] {
    BFIU_BUS_IDLE = 3'b001,
    BFIU_BUS_WR   = 3'b010,
    BFIU_BUS_RD   = 3'b100
  } bfiu_bus_state_t;

endpackage : bfiu_pkg

// file: core/bfiu_alu_if.sv
// operand and result bundle between the sequencer and the datapath
`timescale 1ns/1ps
`default_nettype none
interface bfiu_alu_if;
  bfiu_pkg::bfiu_op_t op;
  logic [2:0]         bitSel;
  logic [7:0]         operand;
  logic [7:0]         flagsIn;
  logic [7:0]         result;
  logic [7:0]         flagsOut;

  modport core (output op, output bitSel, output operand, output flagsIn,
                input result, input flagsOut);
  modport alu  (input op, input bitSel, input operand, input flagsIn,
                output result, output flagsOut);
endinterface : bfiu_alu_if
`default_nettype wire

// file: core/bfiu_alu.sv
// combinational shift, bit transfer and flag datapath
`timescale 1ns/1ps
`default_nettype none
`include "bfiu_params.svh"
module bfiu_alu (
  bfiu_alu_if.alu aluBus
);
  logic [7:0] res;
  logic [7:0] fl;
  logic       shiftOut;
  logic       updArith;

  always_comb begin
    res      = aluBus.operand;
    fl       = aluBus.flagsIn;
    shiftOut = 1'b0;
    updArith = 1'b0;
    unique case (aluBus.op)
      bfiu_pkg::BFIU_OP_ROL: begin
        res      = {aluBus.operand[6:0], aluBus.flagsIn[`BFIU_FLAG_C]};
        shiftOut = aluBus.operand[7];
        updArith = 1'b1;
      end
      bfiu_pkg::BFIU_OP_ROR: begin
        res      = {aluBus.flagsIn[`BFIU_FLAG_C], aluBus.operand[7:1]};
        shiftOut = aluBus.operand[0];
        updArith = 1'b1;
      end
      bfiu_pkg::BFIU_OP_LSR: begin
        res      = {1'b0, aluBus.operand[7:1]};
        shiftOut = aluBus.operand[0];
        updArith = 1'b1;
      end
      bfiu_pkg::BFIU_OP_ASR: begin
        res      = {aluBus.operand[7], aluBus.operand[7:1]};
        shiftOut = aluBus.operand[0];
        updArith = 1'b1;
      end
      bfiu_pkg::BFIU_OP_SWAP: res = {aluBus.operand[3:0], aluBus.operand[7:4]};
      bfiu_pkg::BFIU_OP_BST:  fl[`BFIU_FLAG_T] = aluBus.operand[aluBus.bitSel];
      bfiu_pkg::BFIU_OP_BLD:  res[aluBus.bitSel] = aluBus.flagsIn[`BFIU_FLAG_T];
      bfiu_pkg::BFIU_OP_FSET: fl[aluBus.bitSel] = 1'b1;
      bfiu_pkg::BFIU_OP_FCLR: fl[aluBus.bitSel] = 1'b0;
      default: begin
        res = aluBus.operand;
      end
    endcase
    if (updArith) begin
      fl[`BFIU_FLAG_C] = shiftOut;
      fl[`BFIU_FLAG_Z] = (res == 8'h00);
      fl[`BFIU_FLAG_N] = res[7];
      fl[`BFIU_FLAG_V] = res[7] ^ shiftOut;
    end
    aluBus.result   = res;
    aluBus.flagsOut = fl;
  end
endmodule : bfiu_alu
`default_nettype wire

// file: core/bfiu_core.sv
// bit and flag instruction unit with its register slave
`timescale 1ns/1ps
`default_nettype none
`include "bfiu_params.svh"

// How it works
// - rotate left through carry, old bit 7 to carry, Z C N V updated, one clock
// - rotate right through carry, old bit 0 to carry, Z C N V updated, one clock
// - bit store copies a chosen operand bit into the copy flag only
// - bit load writes the copy flag into a chosen operand bit, flags kept
// - set or clear carry alone in one clock
// - set or clear negative flag alone in one clock
// - set or clear signed test flag alone in one clock
// - set or clear overflow flag alone in one clock
// - set or clear half carry flag alone in one clock
// - set or clear the copy flag alone
// - sleep takes one clock, keeps flags, raises the sleep request
// - watchdog restart takes one clock, keeps flags, pulses the watchdog
// - break halts only when debugging is enabled and keeps flags
module bfiu_core (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  input  wire logic        debugEnPin,
  output var  logic [7:0]  flagsWord,
  output var  logic        sleepReq,
  output var  logic        wdtRestart,
  output var  logic        debugHalted
);

  bfiu_pkg::bfiu_bus_state_t busState;
  logic [7:0]                busAddr;
  logic [7:0]                operand;
  logic [10:0]               cmdWord;
  logic                      cmdValid;
  logic                      dbgSync1;
  logic                      dbgEn;
  logic                      accept;
  logic                      wrPhase;
  logic                      execFire;
  bfiu_pkg::bfiu_op_t        cmdOp;
  logic [2:0]                cmdSel;
  logic [31:0]               next_hrdata;

  bfiu_alu_if aluBus ();

  bfiu_alu bfiu_alu_inst (
    .aluBus (aluBus.alu)
  );

  assign cmdOp          = bfiu_pkg::bfiu_op_t'(cmdWord[`BFIU_CMD_OP_MSB:`BFIU_CMD_OP_LSB]);
  assign cmdSel         = cmdWord[`BFIU_CMD_SEL_MSB:`BFIU_CMD_SEL_LSB];
  assign aluBus.op      = cmdOp;
  assign aluBus.bitSel  = cmdSel;
  assign aluBus.operand = operand;
  assign aluBus.flagsIn = flagsWord;

  // hsize is not decoded: only whole-word transfers are issued
  assign accept   = hsel && hready && htrans[1];
  assign wrPhase  = (busState == bfiu_pkg::BFIU_BUS_WR);
  // a halted core executes nothing until software resumes it
  assign execFire = cmdValid && !debugHalted;

  // debug enable pin, two-stage synchroniser
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dbgSync1 <= 1'b0;
      dbgEn    <= 1'b0;
    end else begin
      dbgSync1 <= debugEnPin;
      dbgEn    <= dbgSync1;
    end
  end

  // bus phase tracking: writes finish in zero waits, reads take one wait
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busState  <= bfiu_pkg::BFIU_BUS_IDLE;
      busAddr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      unique case (busState)
        bfiu_pkg::BFIU_BUS_IDLE,
        bfiu_pkg::BFIU_BUS_WR: begin
          if (accept) begin
            busAddr   <= haddr[`BFIU_ADDR_W-1:0];
            busState  <= hwrite ? bfiu_pkg::BFIU_BUS_WR : bfiu_pkg::BFIU_BUS_RD;
            hreadyout <= hwrite;
          end else begin
            busState  <= bfiu_pkg::BFIU_BUS_IDLE;
            hreadyout <= 1'b1;
          end
        end
        bfiu_pkg::BFIU_BUS_RD: begin
          busState  <= bfiu_pkg::BFIU_BUS_IDLE;
          hreadyout <= 1'b1;
        end
        default: begin
          busState  <= bfiu_pkg::BFIU_BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // read data mux, loaded during the wait cycle
  always_comb begin
    next_hrdata = 32'h0000_0000;
    unique case (busAddr)
      `BFIU_OFS_FLAGS:   next_hrdata = {24'h00_0000, flagsWord};
      `BFIU_OFS_OPERAND: next_hrdata = {24'h00_0000, operand};
      `BFIU_OFS_CMD:     next_hrdata = {21'h00_0000, cmdWord};
      `BFIU_OFS_STATUS:  next_hrdata = {29'h0000_0000, cmdValid, dbgEn, debugHalted};
      default:           next_hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (busState == bfiu_pkg::BFIU_BUS_RD) begin
      hrdata <= next_hrdata;
    end
  end

  // command register: a write queues one operation for the next edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmdWord  <= `BFIU_CMD_RST;
      cmdValid <= 1'b0;
    end else if (wrPhase && busAddr == `BFIU_OFS_CMD) begin
      cmdWord  <= hwdata[`BFIU_CMD_SEL_MSB:0];
      cmdValid <= 1'b1;
    end else if (execFire) begin
      cmdValid <= 1'b0;
    end
  end

  // flags word: execution wins over a bus write in the same edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flagsWord <= `BFIU_FLAGS_RST;
    end else if (execFire) begin
      flagsWord <= aluBus.flagsOut;
    end else if (wrPhase && busAddr == `BFIU_OFS_FLAGS) begin
      flagsWord <= hwdata[7:0];
    end
  end

  // working register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      operand <= `BFIU_OPERAND_RST;
    end else if (execFire) begin
      operand <= aluBus.result;
    end else if (wrPhase && busAddr == `BFIU_OFS_OPERAND) begin
      operand <= hwdata[7:0];
    end
  end

  // one-cycle requests to the sleep controller and watchdog
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sleepReq   <= 1'b0;
      wdtRestart <= 1'b0;
    end else begin
      sleepReq   <= execFire && cmdOp == bfiu_pkg::BFIU_OP_SLEEP;
      wdtRestart <= execFire && cmdOp == bfiu_pkg::BFIU_OP_WDR;
    end
  end

  // debug halt: break only stops the core while debugging is enabled
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      debugHalted <= 1'b0;
    end else if (execFire && cmdOp == bfiu_pkg::BFIU_OP_BREAK && dbgEn) begin
      debugHalted <= 1'b1;
    end else if (wrPhase && busAddr == `BFIU_OFS_CTRL && hwdata[`BFIU_CTRL_RESUME]) begin
      debugHalted <= 1'b0;
    end
  end

  sequence s_fire(bfiu_pkg::bfiu_op_t o);
    execFire && cmdOp == o;
  endsequence

  sequence s_pulse(logic sig);
    sig ##1 !sig;
  endsequence

  chk_rol_result:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_ROL) |=>
      operand == {$past(operand[6:0]), $past(flagsWord[`BFIU_FLAG_C])} &&
      flagsWord[`BFIU_FLAG_C] == $past(operand[7]) &&
      flagsWord[`BFIU_FLAG_V] == (operand[7] ^ flagsWord[`BFIU_FLAG_C]) &&
      flagsWord[7:4] == $past(flagsWord[7:4]))
    else $error("rotate left result or flags wrong");

  chk_ror_result:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_ROR) |=>
      operand == {$past(flagsWord[`BFIU_FLAG_C]), $past(operand[7:1])} &&
      flagsWord[`BFIU_FLAG_C] == $past(operand[0]) &&
      flagsWord[`BFIU_FLAG_Z] == (operand == 8'h00) &&
      flagsWord[`BFIU_FLAG_N] == operand[7])
    else $error("rotate right result or flags wrong");

  chk_bst_copy:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_BST) |=>
      flagsWord[`BFIU_FLAG_T] == $past(operand[cmdSel]) &&
      (flagsWord ^ $past(flagsWord)) == ((flagsWord ^ $past(flagsWord)) & 8'h40) &&
      operand == $past(operand))
    else $error("bit store touched more than the copy flag");

  chk_bld_load:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_BLD) |=>
      operand[$past(cmdSel)] == $past(flagsWord[`BFIU_FLAG_T]) &&
      flagsWord == $past(flagsWord))
    else $error("bit load wrong or flags changed");

  chk_flag_set:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_FSET) |=>
      flagsWord == ($past(flagsWord) | (8'h01 << $past(cmdSel))) &&
      operand == $past(operand))
    else $error("flag set changed other bits");

  chk_flag_clear:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_FCLR) |=>
      flagsWord == ($past(flagsWord) & ~(8'h01 << $past(cmdSel))))
    else $error("flag clear changed other bits");

  chk_sleep_pulse:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_SLEEP) |=>
      s_pulse(sleepReq) and (flagsWord == $past(flagsWord)))
    else $error("sleep request not a single pulse");

  chk_wdr_pulse:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_WDR) |=>
      s_pulse(wdtRestart) and (flagsWord == $past(flagsWord)))
    else $error("watchdog restart not a single pulse");

  chk_break_gate:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_BREAK) |=>
      debugHalted == ($past(debugHalted) || $past(dbgEn)) &&
      flagsWord == $past(flagsWord))
    else $error("break halt not gated by debug enable");

  chk_shift_fill:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_fire(bfiu_pkg::BFIU_OP_LSR) or s_fire(bfiu_pkg::BFIU_OP_ASR)) |=>
      operand[6:0] == $past(operand[7:1]) &&
      operand[7] == ($past(cmdOp) == bfiu_pkg::BFIU_OP_ASR && $past(operand[7])) &&
      flagsWord[`BFIU_FLAG_C] == $past(operand[0]))
    else $error("shift right fill or carry wrong");

  chk_swap_halves:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_SWAP) |=>
      operand == {$past(operand[3:0]), $past(operand[7:4])} &&
      flagsWord == $past(flagsWord))
    else $error("nibble swap wrong or flags changed");

  chk_cmd_single:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    execFire && !(wrPhase && busAddr == `BFIU_OFS_CMD) |=> !cmdValid)
    else $error("command executed for more than one clock");

  chk_rol_flags:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_ROL) |=>
      flagsWord[`BFIU_FLAG_Z] == (operand == 8'h00) &&
      flagsWord[`BFIU_FLAG_N] == operand[7])
    else $error("rotate left zero or negative flag wrong");

  chk_ror_flags:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_ROR) |=>
      flagsWord[`BFIU_FLAG_V] == (operand[7] ^ flagsWord[`BFIU_FLAG_C]) &&
      flagsWord[7:4] == $past(flagsWord[7:4]))
    else $error("rotate right overflow or upper flags wrong");

  chk_shift_flags:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_fire(bfiu_pkg::BFIU_OP_LSR) or s_fire(bfiu_pkg::BFIU_OP_ASR)) |=>
      flagsWord[`BFIU_FLAG_Z] == (operand == 8'h00) &&
      flagsWord[`BFIU_FLAG_N] == operand[7] &&
      flagsWord[`BFIU_FLAG_V] == (operand[7] ^ flagsWord[`BFIU_FLAG_C]) &&
      flagsWord[7:4] == $past(flagsWord[7:4]))
    else $error("shift right flags wrong");

  chk_bld_others:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_fire(bfiu_pkg::BFIU_OP_BLD) |=>
      ((operand ^ $past(operand)) & ~(8'h01 << $past(cmdSel))) == 8'h00)
    else $error("bit load changed an unselected bit");

  chk_halt_hold:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    debugHalted && !(wrPhase && busAddr == `BFIU_OFS_CTRL && hwdata[`BFIU_CTRL_RESUME]) |=>
      debugHalted)
    else $error("debug halt left without resume");

  chk_halt_queue:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    cmdValid && debugHalted |=> cmdValid)
    else $error("queued command lost while halted");

  chk_sleep_cause:
  assert property (@(posedge sys_clk) disable iff (sys_rst)
    sleepReq |-> $past(execFire) && $past(cmdOp) == bfiu_pkg::BFIU_OP_SLEEP)
    else $error("sleep request without a sleep operation");

endmodule : bfiu_core
`default_nettype wire

// file: dv/bfiu_ahb_master.sv
// bus master model standing in for the decoder side of the unit
`timescale 1ns/1ps
`default_nettype none
module bfiu_ahb_master (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end

  // one single word transfer; waits on hready without assuming a latency
  task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    // reads see a changing pattern rather than stale write data
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : bfiu_ahb_master
`default_nettype wire

// file: dv/bfiu_core_bench.sv
// self-checking bench for the bit and flag instruction unit
`timescale 1ns/1ps
`default_nettype none
`include "bfiu_params.svh"
module bfiu_core_bench;
  logic        sysClk;
  logic        sysRst;
  logic        debugEn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [7:0]  flagsWord;
  logic        sleepReq;
  logic        wdtRestart;
  logic        debugHalted;
  int          nMismatch;
  int          nChecks;
  int          cycles;

  bfiu_core bfiu_core_inst (
    .sys_clk(sysClk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .debugEnPin(debugEn),
    .flagsWord(flagsWord), .sleepReq(sleepReq), .wdtRestart(wdtRestart),
    .debugHalted(debugHalted)
  );

  bfiu_ahb_master bfiu_ahb_master_inst (
    .clk(sysClk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  initial begin
    sysClk = 1'b0;
    forever #20 sysClk = ~sysClk;
  end

  task automatic testDone();
    if (nMismatch == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : testDone

  // cuts a hang short
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 20000) begin
      nMismatch++;
      testDone();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bfiu_ahb_master_inst.xfer({24'h0, a}, 1'b1, d, x);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bfiu_ahb_master_inst.xfer({24'h0, a}, 1'b0, 32'h0, x);
    chk(x, exp);
    chk(32'(hresp), 32'h0);
  endtask : rdChk

  // loads operand and flags, runs one op, checks flags, pulses and operand
  task automatic caseOp(input bfiu_pkg::bfiu_op_t op, input logic [2:0] sel,
                        input logic [7:0] a, input logic [7:0] f,
                        input logic [7:0] ea, input logic [7:0] ef);
    wr(`BFIU_OFS_OPERAND, 32'(a));
    wr(`BFIU_OFS_FLAGS, 32'(f));
    wr(`BFIU_OFS_CMD, {21'h0, sel, 3'h0, op});
    @(posedge sysClk);
    #1;
    chk(32'(flagsWord), 32'(ef));
    chk(32'(sleepReq), 32'(op == bfiu_pkg::BFIU_OP_SLEEP));
    chk(32'(wdtRestart), 32'(op == bfiu_pkg::BFIU_OP_WDR));
    @(posedge sysClk);
    #1;
    chk({30'h0, sleepReq, wdtRestart}, 32'h0);
    rdChk(`BFIU_OFS_OPERAND, 32'(ea));
  endtask : caseOp

  task automatic resetCase();
    chk({23'h0, flagsWord, debugHalted}, 32'h0);
    rdChk(`BFIU_OFS_FLAGS, 32'h0);
    rdChk(`BFIU_OFS_STATUS, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rdChk(8'h20, 32'h0);
  endtask : resetCase

  task automatic shiftCase();
    caseOp(bfiu_pkg::BFIU_OP_ROL, 3'h0, 8'h81, 8'h01, 8'h03, 8'h09);
    caseOp(bfiu_pkg::BFIU_OP_ROL, 3'h0, 8'h40, 8'hF0, 8'h80, 8'hFC);
    caseOp(bfiu_pkg::BFIU_OP_ROR, 3'h0, 8'h01, 8'h00, 8'h00, 8'h0B);
    caseOp(bfiu_pkg::BFIU_OP_ROR, 3'h0, 8'h02, 8'h01, 8'h81, 8'h0C);
    caseOp(bfiu_pkg::BFIU_OP_LSR, 3'h0, 8'h81, 8'h04, 8'h40, 8'h09);
    caseOp(bfiu_pkg::BFIU_OP_LSR, 3'h0, 8'h01, 8'h00, 8'h00, 8'h0B);
    caseOp(bfiu_pkg::BFIU_OP_ASR, 3'h0, 8'h81, 8'h00, 8'hC0, 8'h05);
    caseOp(bfiu_pkg::BFIU_OP_ASR, 3'h0, 8'h02, 8'h0F, 8'h01, 8'h00);
    caseOp(bfiu_pkg::BFIU_OP_SWAP, 3'h0, 8'h3C, 8'hA5, 8'hC3, 8'hA5);
  endtask : shiftCase

  task automatic bitCase();
    caseOp(bfiu_pkg::BFIU_OP_BST, 3'h5, 8'h20, 8'h00, 8'h20, 8'h40);
    caseOp(bfiu_pkg::BFIU_OP_BST, 3'h5, 8'hDF, 8'hFF, 8'hDF, 8'hBF);
    caseOp(bfiu_pkg::BFIU_OP_BLD, 3'h7, 8'h00, 8'h40, 8'h80, 8'h40);
    caseOp(bfiu_pkg::BFIU_OP_BLD, 3'h0, 8'hFF, 8'hBF, 8'hFE, 8'hBF);
  endtask : bitCase

  task automatic flagCase();
    for (int i = 0; i < 8; i++) begin
      caseOp(bfiu_pkg::BFIU_OP_FSET, 3'(i), 8'h5A, 8'h00, 8'h5A, 8'(1 << i));
      caseOp(bfiu_pkg::BFIU_OP_FCLR, 3'(i), 8'hA5, 8'hFF, 8'hA5, ~8'(1 << i));
      caseOp(bfiu_pkg::BFIU_OP_FSET, 3'(i), 8'h00, 8'hFF, 8'h00, 8'hFF);
    end
  endtask : flagCase

  task automatic controlCase();
    caseOp(bfiu_pkg::BFIU_OP_SLEEP, 3'h0, 8'h77, 8'h3C, 8'h77, 8'h3C);
    caseOp(bfiu_pkg::BFIU_OP_WDR, 3'h0, 8'h77, 8'hC3, 8'h77, 8'hC3);
    caseOp(bfiu_pkg::BFIU_OP_BREAK, 3'h0, 8'h5A, 8'h96, 8'h5A, 8'h96);
    chk(32'(debugHalted), 32'h0);
    @(posedge sysClk);
    debugEn <= 1'b1;
    repeat (3) @(posedge sysClk);
    rdChk(`BFIU_OFS_STATUS, 32'h2);
    caseOp(bfiu_pkg::BFIU_OP_BREAK, 3'h0, 8'h5A, 8'h96, 8'h5A, 8'h96);
    chk(32'(debugHalted), 32'h1);
    // a queued op must wait while halted
    wr(`BFIU_OFS_CMD, {21'h0, 3'h0, 3'h0, bfiu_pkg::BFIU_OP_FSET});
    repeat (3) @(posedge sysClk);
    #1;
    chk(32'(flagsWord), 32'h96);
    rdChk(`BFIU_OFS_STATUS, 32'h7);
    wr(`BFIU_OFS_CTRL, 32'h1);
    repeat (3) @(posedge sysClk);
    #1;
    chk(32'(debugHalted), 32'h0);
    chk(32'(flagsWord), 32'h97);
    @(posedge sysClk);
    debugEn <= 1'b0;
  endtask : controlCase

  initial begin
    nMismatch = 0;
    nChecks = 0;
    cycles = 0;
    sysRst = 1'b1;
    debugEn = 1'b0;
    repeat (20) @(posedge sysClk);
    sysRst <= 1'b0;
    #1;
    resetCase();
    shiftCase();
    bitCase();
    flagCase();
    controlCase();
    testDone();
  end
endmodule : bfiu_core_bench
`default_nettype wire
